// ---- hw/pio_channel_dma.sv ----
// Parcel I/O channel: 64-bit memory words moved as four 16-bit parcels.
//
// Overview of operation
// - Async and fast async parity fault sets at once, becomes error when transfer ends.
// - Synchronous parity fault stores every later parcel of the transfer as zeros.
// - Synchronous parity fault raises no interrupt; sets error when transfer ends.
// - Async Ready while inactive: error, interrupt, or held until activation, then Resume.
// - Async Ready during word write or at limit: error, interrupt, no Resume, discard.
// - Fast async Ready during memory write: four Resumes, no sample, error, interrupt.
// - Fast async Ready inactive or at limit: no Resume, no sample, error, interrupt.
// - Synchronous unexpected Ready: error, interrupt, transfer stopped, no Resume.
// - Limit pointer loaded first; writing current pointer activates the channel.
// - Output fetches word, increments pointer, ends after last parcel at limit.
// - Output Resume while inactive sets interrupt, no response on the link.
// - Async input: Resume per parcel; fourth Resume after word write and increment.
// - Async input at limit after write interrupts; stray Disconnect ignored.
// - Four odd parity bits per parcel, one per nibble, checked by receiver.
// - One Ready per parcel, first parcel only on synchronous input; its leading edge times the parcel sample.
// - Output parcels upper first, each Ready a fixed-width pulse.
// - Async output after fourth Resume: fetch next word or Disconnect, interrupt, deactivate.
// - Master clear line driven by programmed clear or global clear event.
// - Async and fast async Disconnect mid-word stores received parcels, missing low parcels as zeros.
// - Input channel deactivates whenever its interrupt flag sets.
`include "pio_map.svh"

module pio_channel_dma (
	// Clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// APB slave
	input  wire logic [7:0]            paddr,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Memory port
	output pio_pkg::pio_mem_req_s      mem_req,
	input  wire logic                  mem_ack,
	input  wire logic [63:0]           mem_rdata,
	// Input link
	input  wire pio_pkg::pio_parcel_s  rx_parcel,
	input  wire logic                  rx_ready,
	input  wire logic                  rx_disconnect,
	output logic                       rx_resume,
	// Output link
	output pio_pkg::pio_parcel_s       tx_parcel,
	output logic                       tx_ready,
	output logic                       tx_disconnect,
	input  wire logic                  tx_resume,
	// Channel control
	input  wire logic                  clear_io,
	output logic                       master_clear,
	output logic                       chan_int,
	output logic                       chan_active
);

	pio_pkg::pio_state_s  st_reg;
	pio_pkg::pio_state_s  st_next;
	pio_pkg::pio_parcel_s rx_s;
	logic [22:0]          s_lvl;
	logic [22:0]          s_rise;
	logic [3:0]           rx_bad;
	logic [3:0]           tx_par;
	logic [`PIO_AW-1:0]   ca_inc;
	logic                 ev_rdy;
	logic                 ev_dis;
	logic                 ev_res;
	logic                 p_high;
	logic                 busy;
	logic                 at_lim;
	logic                 hit;
	logic                 take;
	logic                 end_x;
	logic                 act_go;
	logic [15:0]          pdat;

	// -------------------------------------------------------------------------
	// Link synchronisation
	// -------------------------------------------------------------------------
	// edge detection
	pio_sync3 #(
		.W(23)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pins    ({rx_ready, rx_disconnect, tx_resume, rx_parcel}),
		.level   (s_lvl),
		.rise    (s_rise)
	);

	assign ev_rdy = s_rise[22];
	assign ev_dis = s_rise[21];
	assign ev_res = s_rise[20];
	assign rx_s   = s_lvl[19:0];

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_par
			assign rx_bad[g] = ~^{rx_s.par[g], rx_s.data[4*g+3:4*g]};
			assign tx_par[g] = ~^st_reg.odata[4*g+3:4*g];
		end
	endgenerate

	// -------------------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------------------
	// Parcel 0 sits in the top sixteen bits of the word.
	function automatic logic [6:0] f_sh(input logic [1:0] i);
		return 7'd48 - {1'b0, i, 4'h0};
	endfunction : f_sh

	function automatic pio_pkg::pio_state_s f_pulse(input pio_pkg::pio_state_s s,
			input pio_pkg::pio_kind_e k, input logic [2:0] cnt);
		s.kind = k;
		s.left = cnt;
		s.pcnt = 5'h0;
		return s;
	endfunction : f_pulse

	assign busy   = st_reg.left != 3'h0;
	assign p_high = busy && (st_reg.pcnt < 5'(`PIO_PULSE_CYC));
	assign at_lim = st_reg.ca == st_reg.cl;
	assign ca_inc = st_reg.ca + `PIO_AW'(1);
	assign hit    = (paddr == `PIO_OFS_CTRL) || (paddr == `PIO_OFS_LIMIT) ||
	                (paddr == `PIO_OFS_CURR) || (paddr == `PIO_OFS_STAT);
	assign pdat   = (st_reg.vsel == pio_pkg::V_SYNC && st_reg.pfault) ? 16'h0 : rx_s.data;

	// -------------------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		take    = 1'b0;
		end_x   = 1'b0;
		act_go  = 1'b0;

		// Pulse engine: fixed width, fixed spacing between pulses of a burst.
		if (busy) begin
			if (st_reg.pcnt == 5'(`PIO_PERIOD_CYC - 1)) begin
				st_next.pcnt = 5'h0;
				st_next.left = st_reg.left - 3'h1;
				if (st_reg.kind == pio_pkg::K_RDY && st_reg.left > 3'h1) begin
					st_next.idx   = st_reg.idx + 2'h1;
					st_next.odata = 16'(st_reg.word >> f_sh(st_reg.idx + 2'h1));
				end
			end else begin
				st_next.pcnt = st_reg.pcnt + 5'h1;
			end
		end
		if (st_reg.tcnt != 5'h0) begin
			st_next.tcnt = st_reg.tcnt - 5'h1;
		end
		if (st_reg.mcnt != 5'h0) begin
			st_next.mcnt = st_reg.mcnt - 5'h1;
		end

		// APB: read data is captured in the setup phase, writes act in access.
		if (psel && !penable) begin
			unique case (paddr)
				`PIO_OFS_CTRL:  st_next.prdata = {27'h0, st_reg.rmode, st_reg.vsel,
				                                  st_reg.dir};
				`PIO_OFS_LIMIT: st_next.prdata = 32'(st_reg.cl);
				`PIO_OFS_CURR:  st_next.prdata = 32'(st_reg.ca);
				`PIO_OFS_STAT:  st_next.prdata = {27'h0, st_reg.held, st_reg.pfault,
				                                  st_reg.errf, st_reg.intf, st_reg.active};
				default:        st_next.prdata = 32'h0;
			endcase
		end
		if (psel && penable && pwrite) begin
			unique case (paddr)
				`PIO_OFS_CTRL: begin
					st_next.dir   = pwdata[`PIO_CTRL_DIR];
					st_next.vsel  = pio_pkg::pio_var_e'(pwdata[`PIO_CTRL_VAR+1:`PIO_CTRL_VAR]);
					st_next.rmode = pwdata[`PIO_CTRL_RMODE+1:`PIO_CTRL_RMODE];
					if (pwdata[`PIO_CTRL_MCLR]) begin
						st_next.mcnt = 5'(`PIO_PULSE_CYC);
					end
				end
				`PIO_OFS_LIMIT: st_next.cl = pwdata[`PIO_AW-1:0];
				`PIO_OFS_CURR: begin
					st_next.ca = pwdata[`PIO_AW-1:0];
					act_go     = 1'b1;
				end
				`PIO_OFS_STAT: begin
					if (pwdata[`PIO_STAT_INT]) begin
						st_next.intf = 1'b0;
						st_next.errf = 1'b0;
					end
				end
				default: ;
			endcase
		end

		if (act_go) begin
			st_next.active    = 1'b1;
			st_next.idx       = 2'h0;
			st_next.word      = 64'h0;
			st_next.got_first = 1'b0;
			st_next.fin       = 1'b0;
			st_next.ack_seen  = 1'b0;
			st_next.pfault    = 1'b0;
			if (st_next.dir) begin
				st_next.st  = pio_pkg::ST_MEM;
				st_next.mem = '{req: 1'b1, we: 1'b0, addr: pwdata[`PIO_AW-1:0], wdata: 64'h0};
			end else begin
				st_next.st = pio_pkg::ST_RUN;
				if (st_next.vsel == pio_pkg::V_HS) begin
					st_next = f_pulse(st_next, pio_pkg::K_RES, 3'h4);
				end else if (st_next.vsel == pio_pkg::V_SYNC) begin
					st_next = f_pulse(st_next, pio_pkg::K_RES, 3'h1);
				end else if (st_reg.held) begin
					// The held parcel is still on the lines, so it becomes parcel 0.
					st_next        = f_pulse(st_next, pio_pkg::K_RES, 3'h1);
					st_next.held   = 1'b0;
					st_next.word   = 64'(rx_s.data) << f_sh(2'h0);
					st_next.idx    = 2'h1;
					st_next.pfault = rx_bad != 4'h0;
				end
			end
		end

		if (!st_reg.dir) begin
			// ---------------- Input channel ----------------
			if (ev_rdy) begin
				if (!st_reg.active) begin
					if (st_reg.vsel != pio_pkg::V_ASYNC || st_reg.rmode == 2'h0) begin
						st_next.errf = 1'b1;
						st_next.intf = 1'b1;
					end else if (st_reg.rmode == 2'h1) begin
						st_next.intf = 1'b1;
					end else begin
						st_next.held = 1'b1;
					end
				end else if (st_reg.vsel == pio_pkg::V_SYNC) begin
					if (at_lim || st_reg.got_first || st_reg.st != pio_pkg::ST_RUN) begin
						st_next.errf   = 1'b1;
						st_next.intf   = 1'b1;
						st_next.active = 1'b0;
						st_next.tcnt   = 5'h0;
					end else begin
						take = 1'b1;
					end
				end else if (st_reg.st == pio_pkg::ST_MEM || at_lim) begin
					st_next.errf   = 1'b1;
					st_next.intf   = 1'b1;
					st_next.active = 1'b0;
					if (st_reg.vsel == pio_pkg::V_HS && st_reg.st == pio_pkg::ST_MEM) begin
						st_next = f_pulse(st_next, pio_pkg::K_RES, 3'h4);
					end
				end else begin
					take = 1'b1;
				end
			end
			if (st_reg.vsel == pio_pkg::V_SYNC && st_reg.tcnt == 5'h1 && st_reg.active &&
			    st_reg.st == pio_pkg::ST_RUN) begin
				take = 1'b1;
			end

			if (take) begin
				st_next.word = st_reg.word | (64'(pdat) << f_sh(st_reg.idx));
				if (rx_bad != 4'h0) begin
					st_next.pfault = 1'b1;
				end
				if (st_reg.vsel == pio_pkg::V_SYNC) begin
					st_next.got_first = 1'b1;
				end
				if (st_reg.idx == 2'h3) begin
					st_next.idx = 2'h0;
					st_next.st  = pio_pkg::ST_MEM;
					st_next.mem = '{req: 1'b1, we: 1'b1, addr: st_reg.ca, wdata: st_next.word};
				end else begin
					st_next.idx = st_reg.idx + 2'h1;
					if (st_reg.vsel == pio_pkg::V_ASYNC) begin
						st_next = f_pulse(st_next, pio_pkg::K_RES, 3'h1);
					end else if (st_reg.vsel == pio_pkg::V_SYNC) begin
						st_next      = f_pulse(st_next, pio_pkg::K_RES, 3'h1);
						st_next.tcnt = 5'(`PIO_SAMPLE_CYC);
					end
				end
			end

			if (ev_dis && st_reg.active &&
			    ((st_reg.vsel == pio_pkg::V_ASYNC && !at_lim) || st_reg.vsel == pio_pkg::V_HS ||
			     (st_reg.vsel == pio_pkg::V_SYNC && at_lim))) begin
				if (st_reg.st == pio_pkg::ST_MEM) begin
					st_next.fin = 1'b1;
				end else if (st_reg.idx != 2'h0) begin
					st_next.fin = 1'b1;
					st_next.st  = pio_pkg::ST_MEM;
					st_next.mem = '{req: 1'b1, we: 1'b1, addr: st_reg.ca, wdata: st_reg.word};
				end else begin
					end_x = 1'b1;
				end
			end

			if (st_reg.st == pio_pkg::ST_MEM && mem_ack) begin
				st_next.mem.req = 1'b0;
				st_next.ca      = ca_inc;
				st_next.word    = 64'h0;
				st_next.st      = pio_pkg::ST_RUN;
				if (st_reg.fin || st_next.fin) begin
					end_x = 1'b1;
				end else if (st_next.active) begin
					unique case (st_reg.vsel)
						pio_pkg::V_ASYNC: begin
							st_next = f_pulse(st_next, pio_pkg::K_RES, 3'h1);
							if (ca_inc == st_reg.cl) begin
								end_x = 1'b1;
							end
						end
						pio_pkg::V_HS: begin
							if (ca_inc != st_reg.cl) begin
								st_next = f_pulse(st_next, pio_pkg::K_RES, 3'h4);
							end
						end
						default: begin
							if (ca_inc != st_reg.cl) begin
								st_next      = f_pulse(st_next, pio_pkg::K_RES, 3'h1);
								st_next.tcnt = 5'(`PIO_SAMPLE_CYC);
							end
						end
					endcase
				end
			end
		end else begin
			// ---------------- Output channel ----------------
			if (ev_res) begin
				if (!st_reg.active) begin
					st_next.intf = 1'b1;
				end else if (st_reg.st == pio_pkg::ST_RUN) begin
					st_next.ack_seen = 1'b1;
				end
			end
			if (st_reg.st == pio_pkg::ST_RUN && !busy) begin
				if (st_reg.kick) begin
					st_next.kick  = 1'b0;
					st_next.odata = 16'(st_reg.word >> f_sh(2'h0));
					st_next = f_pulse(st_next, pio_pkg::K_RDY,
					                  (st_reg.vsel == pio_pkg::V_ASYNC) ? 3'h1 : 3'h4);
				end else if (st_reg.ack_seen) begin
					st_next.ack_seen = 1'b0;
					if (st_reg.vsel == pio_pkg::V_ASYNC && st_reg.idx != 2'h3) begin
						st_next.idx   = st_reg.idx + 2'h1;
						st_next.odata = 16'(st_reg.word >> f_sh(st_reg.idx + 2'h1));
						st_next       = f_pulse(st_next, pio_pkg::K_RDY, 3'h1);
					end else if (!at_lim) begin
						st_next.st  = pio_pkg::ST_MEM;
						st_next.mem = '{req: 1'b1, we: 1'b0, addr: st_reg.ca, wdata: 64'h0};
					end else begin
						if (st_reg.vsel == pio_pkg::V_ASYNC) begin
							st_next = f_pulse(st_next, pio_pkg::K_DIS, 3'h1);
						end
						end_x = 1'b1;
					end
				end
			end
			if (st_reg.st == pio_pkg::ST_MEM && mem_ack) begin
				st_next.mem.req  = 1'b0;
				st_next.word     = mem_rdata;
				st_next.ca       = ca_inc;
				st_next.last     = ca_inc == st_reg.cl;
				st_next.idx      = 2'h0;
				st_next.kick     = 1'b1;
				st_next.ack_seen = 1'b0;
				st_next.st       = st_reg.active ? pio_pkg::ST_RUN : pio_pkg::ST_IDLE;
			end
		end

		if (end_x) begin
			st_next.intf   = 1'b1;
			st_next.active = 1'b0;
			st_next.errf   = st_next.errf | st_next.pfault;
			st_next.pfault = 1'b0;
		end
		if (!st_next.active && st_next.st == pio_pkg::ST_RUN) begin
			st_next.st = pio_pkg::ST_IDLE;
		end

		// A global clear abandons any memory request in flight.
		if (clear_io) begin
			st_next.st      = pio_pkg::ST_IDLE;
			st_next.active  = 1'b0;
			st_next.held    = 1'b0;
			st_next.left    = 3'h0;
			st_next.tcnt    = 5'h0;
			st_next.mem.req = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg    <= '0;
			st_reg.st <= pio_pkg::ST_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	// -------------------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------------------
	assign prdata        = st_reg.prdata;
	assign pready        = 1'b1;
	assign pslverr       = psel && penable && !hit;
	assign mem_req       = st_reg.mem;
	assign rx_resume     = p_high && st_reg.kind == pio_pkg::K_RES;
	assign tx_ready      = p_high && st_reg.kind == pio_pkg::K_RDY;
	assign tx_disconnect = p_high && (st_reg.kind == pio_pkg::K_DIS ||
	                       (st_reg.kind == pio_pkg::K_RDY && st_reg.last &&
	                        st_reg.left == 3'h1 && st_reg.vsel != pio_pkg::V_ASYNC));
	assign tx_parcel     = '{data: st_reg.odata, par: tx_par};
	assign master_clear  = (st_reg.mcnt != 5'h0) || clear_io;
	assign chan_int      = st_reg.intf;
	assign chan_active   = st_reg.active;

endmodule : pio_channel_dma

// ---- shared/pio_map.svh ----
// Register offsets, field positions and timing counts of the parcel I/O channel.
`ifndef PIO_MAP_SVH
`define PIO_MAP_SVH

// -----------------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------------
`define PIO_AW            24
`define PIO_OFS_CTRL      8'h00
`define PIO_OFS_LIMIT     8'h04
`define PIO_OFS_CURR      8'h08
`define PIO_OFS_STAT      8'h0c
`define PIO_CTRL_DIR      0
`define PIO_CTRL_VAR      1
`define PIO_CTRL_RMODE    3
`define PIO_CTRL_MCLR     8
`define PIO_STAT_ACTIVE   0
`define PIO_STAT_INT      1
`define PIO_STAT_ERR      2
`define PIO_STAT_PFAULT   3
`define PIO_STAT_HELD     4

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define PIO_CLK_NS        8
`define PIO_PULSE_NS      50
`define PIO_PERIOD_NS     100
`define PIO_SAMPLE_NS     90
`define PIO_PULSE_CYC     ((`PIO_PULSE_NS + `PIO_CLK_NS - 1) / `PIO_CLK_NS)
`define PIO_PERIOD_CYC    ((`PIO_PERIOD_NS + `PIO_CLK_NS - 1) / `PIO_CLK_NS)
`define PIO_SAMPLE_CYC    ((`PIO_SAMPLE_NS + `PIO_CLK_NS - 1) / `PIO_CLK_NS)

`endif

// ---- shared/pio_pkg.sv ----
// Types shared by the parcel I/O channel design.
`include "pio_map.svh"

package pio_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_MEM  = 3'b010,
		ST_RUN  = 3'b100
	} pio_state_e;

	typedef enum logic [1:0] {
		V_ASYNC = 2'h0,
		V_HS    = 2'h1,
		V_SYNC  = 2'h2
	} pio_var_e;

	typedef enum logic [1:0] {
		K_RES = 2'h0,
		K_RDY = 2'h1,
		K_DIS = 2'h2
	} pio_kind_e;

	typedef struct packed {
		logic [15:0] data;
		logic [3:0]  par;
	} pio_parcel_s;

	typedef struct packed {
		logic                  req;
		logic                  we;
		logic [`PIO_AW-1:0]    addr;
		logic [63:0]           wdata;
	} pio_mem_req_s;

	typedef struct packed {
		pio_state_e            st;
		logic                  dir;
		pio_var_e              vsel;
		logic [1:0]            rmode;
		logic                  active;
		logic                  intf;
		logic                  errf;
		logic                  pfault;
		logic                  held;
		logic                  got_first;
		logic                  fin;
		logic                  ack_seen;
		logic                  kick;
		logic                  last;
		logic [1:0]            idx;
		logic [`PIO_AW-1:0]    ca;
		logic [`PIO_AW-1:0]    cl;
		logic [63:0]           word;
		logic [15:0]           odata;
		pio_kind_e             kind;
		logic [2:0]            left;
		logic [4:0]            pcnt;
		logic [4:0]            tcnt;
		logic [4:0]            mcnt;
		logic [31:0]           prdata;
		pio_mem_req_s          mem;
	} pio_state_s;

endpackage : pio_pkg

// ---- hw/pio_sync3.sv ----
// Three-stage pin synchroniser with leading-edge detection.
module pio_sync3 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Pin side
	input  wire logic [W-1:0] pins,
	// Synchronised side
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
	} pio_sync_s;

	pio_sync_s    sy_reg;
	pio_sync_s    sy_next;
	logic [W-1:0] agree;

	// A change is believed only once the second and third stages agree.
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			assign agree[i] = sy_reg.s2[i] ~^ sy_reg.s3[i];
			assign level[i] = agree[i] ? sy_reg.s3[i] : sy_reg.lvl[i];
			assign rise[i]  = level[i] & ~sy_reg.lvl[i];
		end
	endgenerate

	always_comb begin
		sy_next.s1  = pins;
		sy_next.s2  = sy_reg.s1;
		sy_next.s3  = sy_reg.s2;
		sy_next.lvl = level;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sy_reg <= '0;
		end else begin
			sy_reg <= sy_next;
		end
	end

endmodule : pio_sync3

// ---- verif/pio_chk_asserts.sv ----
// Port-level assertions for the parcel I/O channel.
`include "pio_map.svh"

module pio_chk (
	// Clock and reset
	input wire logic                  pclk,
	input wire logic                  presetn,
	// Register bus
	input wire logic [7:0]            paddr,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	// Links and memory
	input wire logic                  rx_resume,
	input wire pio_pkg::pio_parcel_s  tx_parcel,
	input wire logic                  tx_ready,
	input wire logic                  tx_disconnect,
	input wire pio_pkg::pio_mem_req_s mem_req,
	input wire logic                  mem_ack,
	// Control
	input wire logic                  clear_io,
	input wire logic                  master_clear,
	input wire logic                  chan_int,
	input wire logic                  chan_active
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_pulse(x);
		x[*7] ##1 !x;
	endsequence

	a_rdy_pulse: assert property ($rose(tx_ready) |-> s_pulse(tx_ready))
		else $error("output ready pulse has wrong width");
	a_res_pulse: assert property ($rose(rx_resume) |-> s_pulse(rx_resume))
		else $error("resume pulse has wrong width");
	a_tx_parity: assert property (tx_parcel.par == ~{^tx_parcel.data[15:12],
		^tx_parcel.data[11:8], ^tx_parcel.data[7:4], ^tx_parcel.data[3:0]})
		else $error("output parcel parity is not odd");
	a_tx_hold: assert property (tx_ready && $past(tx_ready) |-> $stable(tx_parcel))
		else $error("output parcel changed during ready");
	a_mclr_io: assert property (clear_io |-> master_clear)
		else $error("master clear missing on global clear");
	a_act_load: assert property (psel && penable && pwrite && paddr == `PIO_OFS_CURR
		&& !clear_io |=> chan_active)
		else $error("current pointer write did not activate");
	a_req_hold: assert property (mem_req.req && !mem_ack && !clear_io
		|=> mem_req.req && $stable(mem_req))
		else $error("memory request dropped before acknowledge");
	a_int_idle: assert property ($rose(chan_int) |-> ##[0:40] !chan_active)
		else $error("channel stayed active after interrupt");
	a_disc_int: assert property ($rose(tx_disconnect) |-> ##[0:12] chan_int)
		else $error("no interrupt after output disconnect");
endmodule : pio_chk

bind pio_channel_dma pio_chk u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
	.rx_resume, .tx_parcel, .tx_ready, .tx_disconnect, .mem_req, .mem_ack, .clear_io,
	.master_clear, .chan_int, .chan_active);

// ---- verif/pio_peer.sv ----
// Far-side device model: sends input parcels and answers output parcels.
module pio_peer (
	input  wire logic                 pclk,
	output pio_pkg::pio_parcel_s      rx_parcel,
	output logic                      rx_ready,
	output logic                      rx_disconnect,
	input  wire logic                 rx_resume,
	input  wire pio_pkg::pio_parcel_s tx_parcel,
	input  wire logic                 tx_ready,
	output logic                      tx_resume
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] got [$];
	initial begin
		rx_parcel = 20'h5a5a5;
		rx_ready = 1'b0;
		rx_disconnect = 1'b0;
		tx_resume = 1'b0;
	end
	function automatic logic [3:0] par(input logic [15:0] d);
		return ~{^d[15:12], ^d[11:8], ^d[7:4], ^d[3:0]};
	endfunction : par
	task automatic send(input logic [15:0] d, input logic [3:0] bad, output logic ok);
		ok = 1'b0;
		rx_parcel <= {d, par(d) ^ bad};
		rx_ready <= 1'b1;
		for (int n = 0; n < 300 && !(ok && n > 6); n++) begin
			@(posedge pclk);
			if (n == 5)
				rx_ready <= 1'b0;
			ok = ok | rx_resume;
		end
		while (rx_resume) @(posedge pclk);
		// Released lines show no stale value.
		rx_parcel <= ~rx_parcel;
		repeat (8) @(posedge pclk);
	endtask : send
	task automatic disc();
		rx_disconnect <= 1'b1;
		repeat (6) @(posedge pclk);
		rx_disconnect <= 1'b0;
	endtask : disc
	task automatic kick();
		tx_resume <= 1'b1;
		repeat (6) @(posedge pclk);
		tx_resume <= 1'b0;
	endtask : kick
	initial forever begin
		@(posedge pclk iff tx_ready);
		got.push_back(tx_parcel.data);
		repeat ($urandom_range(7, 30)) @(posedge pclk);
		kick();
	end
endmodule : pio_peer

// ---- verif/testbench.sv ----
// Self-checking bench for the parcel I/O channel.
`include "pio_map.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  pclk, presetn, psel, penable, pwrite, mem_ack, clear_io, ok, err;
	logic                  pready, pslverr, rx_ready, rx_disconnect, rx_resume, tx_ready;
	logic                  tx_disconnect, tx_resume, master_clear, chan_int, chan_active, am;
	logic [7:0]            paddr;
	logic [31:0]           pwdata, prdata, rv;
	logic [63:0]           mem_rdata;
	logic [23:0]           b;
	logic [15:0]           d [4];
	logic [31:0]           vs [3] = '{32'h0, 32'h2, 32'h4};
	logic [63:0]           mem [logic [23:0]];
	pio_pkg::pio_mem_req_s mem_req;
	pio_pkg::pio_parcel_s  rx_parcel, tx_parcel;
	int                    miscompares, n_checks;

	pio_channel_dma DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .mem_req, .mem_ack, .mem_rdata, .rx_parcel, .rx_ready,
		.rx_disconnect, .rx_resume, .tx_parcel, .tx_ready, .tx_disconnect, .tx_resume,
		.clear_io, .master_clear, .chan_int, .chan_active);
	pio_peer peer (.pclk, .rx_parcel, .rx_ready, .rx_disconnect, .rx_resume, .tx_parcel,
		.tx_ready, .tx_resume);

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// Memory acknowledges after a random wait; idle data toggles.
	always @(posedge pclk) begin
		am = mem_req.req && !mem_ack && $urandom_range(0, 2) == 0;
		mem_ack <= am;
		mem_rdata <= (am && !mem_req.we) ? mem[mem_req.addr] : ~mem_rdata;
		if (am && mem_req.we)
			mem[mem_req.addr] = mem_req.wdata;
	end
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wint();
		for (int i = 0; i < 3000 && chan_int !== 1'b1; i++) @(posedge pclk);
		chk(chan_int, 1'b1);
	endtask : wint
	function automatic logic [15:0] pcl(input logic [63:0] w, input int k);
		return w[63 - 16 * k -: 16];
	endfunction : pcl
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	initial begin
		#200us;
		miscompares++;
		wrap_up();
	end

	initial begin
		{psel, penable, pwrite, mem_ack, clear_io, presetn} = '0;
		paddr = '0;
		pwdata = '0;
		mem_rdata = '0;
		void'($urandom(32'ha0bc));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `PIO_OFS_STAT, 0);
		chk(rv, 0);
		apb(1, 8'h14, 32'hffffffff);
		chk(err, 1'b1);
		b = 24'($urandom) & 24'hfffff0;
		for (int i = 0; i < 2; i++)
			mem[b + 24'(i)] = {$urandom, $urandom};
		apb(1, `PIO_OFS_CTRL, 32'h1);
		apb(1, `PIO_OFS_LIMIT, 32'(b + 2));
		apb(1, `PIO_OFS_CURR, 32'(b));
		wint();
		for (int i = 0; i < 8; i++)
			chk(peer.got.pop_front(), pcl(mem[b + 24'(i / 4)], i % 4));
		apb(0, `PIO_OFS_CURR, 0);
		chk(rv, 32'(b + 2));
		apb(1, `PIO_OFS_STAT, 32'h2);
		peer.kick();
		repeat (12) @(posedge pclk);
		chk(chan_int, 1'b1);
		chk(peer.got.size(), 0);
		apb(1, `PIO_OFS_STAT, 32'h2);
		apb(1, `PIO_OFS_CTRL, 32'h0);
		apb(1, `PIO_OFS_LIMIT, 32'(b + 1));
		apb(1, `PIO_OFS_CURR, 32'(b));
		for (int i = 0; i < 4; i++) begin
			d[i] = (i == 0) ? 16'hffff : 16'($urandom);
			peer.send(d[i], 4'h0, ok);
			chk(ok, 1'b1);
		end
		wint();
		chk(mem[b], {d[0], d[1], d[2], d[3]});
		apb(1, `PIO_OFS_STAT, 32'h2);
		peer.disc();
		repeat (8) @(posedge pclk);
		chk(chan_int, 1'b0);
		apb(1, `PIO_OFS_CTRL, 32'h10);
		fork
			peer.send(16'hbeef, 4'h0, ok);
			begin
				repeat (20) @(posedge pclk);
				apb(0, `PIO_OFS_STAT, 0);
				chk(rv[4], 1'b1);
				apb(1, `PIO_OFS_LIMIT, 32'(b + 2));
				apb(1, `PIO_OFS_CURR, 32'(b));
			end
		join
		chk(ok, 1'b1);
		d[1] = 16'($urandom);
		peer.send(d[1], 4'h4, ok);
		apb(0, `PIO_OFS_STAT, 0);
		chk(rv[3:1], 3'b100);
		peer.disc();
		wint();
		chk(mem[b], {16'hbeef, d[1], 32'h0});
		apb(0, `PIO_OFS_STAT, 0);
		chk(rv[2:0], 3'b110);
		apb(1, `PIO_OFS_CURR, 32'(b));
		clear_io <= 1'b1;
		@(posedge pclk);
		clear_io <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(chan_active, 1'b0);
		apb(1, `PIO_OFS_CTRL, 32'h100);
		@(posedge pclk);
		#1;
		chk(master_clear, 1'b1);
		foreach (vs[i]) begin
			apb(1, `PIO_OFS_STAT, 32'h2);
			apb(1, `PIO_OFS_CTRL, vs[i]);
			peer.send(16'h0f0f, 4'h0, ok);
			chk(ok, 1'b0);
			apb(0, `PIO_OFS_STAT, 0);
			chk(rv[2:1], 2'b11);
		end
		wrap_up();
	end
endmodule : testbench
